// *** rtl/tmh_regs.vh ***
// register offsets, field positions, reset values and prescaler clock select codes for the timer h block
// assumes an 8-bit cpu bus with 16-bit byte addresses
`ifndef TMH_REGS_VH
`define TMH_REGS_VH
// --------------------------------
// register byte addresses
// --------------------------------
`define TMH_ADDR_CH0_CMPA 16'hff18
`define TMH_ADDR_CH0_CMPB 16'hff19
`define TMH_ADDR_CH1_CMPA 16'hff1a
`define TMH_ADDR_CH1_CMPB 16'hff1b
`define TMH_ADDR_CH2_MODE 16'hff42
`define TMH_ADDR_CH2_CMPA 16'hff44
`define TMH_ADDR_CH2_CMPB 16'hff45
// --------------------------------
// reset values
// --------------------------------
`define TMH_RST_CMP 8'h00
`define TMH_RST_MODE 8'h00
// --------------------------------
// mode register fields
// --------------------------------
`define TMH_MODE_ENABLE 7
`define TMH_MODE_CKS_HI 6
`define TMH_MODE_CKS_LO 4
`define TMH_MODE_MD_HI 3
`define TMH_MODE_MD_LO 2
`define TMH_MODE_LEVEL 1
`define TMH_MODE_OUTEN 0
// --------------------------------
// operation mode codes
// --------------------------------
`define TMH_MD_INTERVAL 2'h0
`define TMH_MD_PWM 2'h2
`define TMH_MD_CARRIER 2'h1
// --------------------------------
// prescaler: 12-bit free divider, clock select code per division ratio
// --------------------------------
`define TMH_PRE_W 12
`define TMH_CKS_DIV1 3'h0
`define TMH_CKS_DIV2 3'h1
`define TMH_CKS_DIV4 3'h2
`define TMH_CKS_DIV16 3'h3
`define TMH_CKS_DIV64 3'h4
`define TMH_CKS_DIV1024 3'h5
`define TMH_CKS_DIV4096 3'h6
`endif

// *** rtl/tmh_channel.v ***
// one timer h channel: 8-bit counter with compare a, buffered compare b and output toggle
// assumes the count tick is one clk wide and comes from the parent's prescaler
`timescale 1ns/1ps
`default_nettype none
`include "tmh_regs.vh"
module tmh_channel (
  input wire clk,
  input wire rst_n,
  input wire enable,
  input wire tick,
  input wire [1:0] mode,
  input wire level,
  input wire cmpa_we,
  input wire cmpb_we,
  input wire [7:0] wdata,
  output wire [7:0] cmpa,
  output wire [7:0] cmpb,
  output reg [7:0] count_ff,
  output reg out_ff,
  output reg irq_ff
);
  reg [7:0] cmpa_ff;
  reg [7:0] cmpb_act_ff;
  reg [7:0] cmpb_buf_ff;
  reg cmpb_pend_ff;
  wire match_a;
  wire match_b;
  wire pwm_mode;
  wire carrier_mode;
  assign cmpa = cmpa_ff;
  assign cmpb = cmpb_buf_ff;
  assign pwm_mode = (mode == `TMH_MD_PWM);
  assign carrier_mode = (mode == `TMH_MD_CARRIER);
  // matches only count while a tick lands on the matching value
  assign match_a = enable && tick && (count_ff == cmpa_ff);
  assign match_b = enable && tick && (pwm_mode || carrier_mode) && (count_ff == cmpb_act_ff);
  // --------------------------------
  // compare registers
  // --------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmpa_ff <= `TMH_RST_CMP;
      cmpb_act_ff <= `TMH_RST_CMP;
      cmpb_buf_ff <= `TMH_RST_CMP;
      cmpb_pend_ff <= 1'b0;
    end else begin
      // software keeps compare a fixed while enabled
      if (cmpa_we) begin
        cmpa_ff <= wdata;
      end
      if (cmpb_we) begin
        cmpb_buf_ff <= wdata;
        // a write when stopped is taken at once; while running it waits for a compare b match
        if (!enable) begin
          cmpb_act_ff <= wdata;
          cmpb_pend_ff <= 1'b0;
        end else begin
          cmpb_pend_ff <= 1'b1;
        end
      end else if (match_b && cmpb_pend_ff) begin
        cmpb_act_ff <= cmpb_buf_ff;
        cmpb_pend_ff <= 1'b0;
      end
    end
  end
  // --------------------------------
  // counter, output and interrupt
  // --------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= 8'h00;
      out_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= match_a || (match_b && carrier_mode);
      if (!enable) begin
        count_ff <= 8'h00;
        out_ff <= level;
      end else begin
        if (match_b && carrier_mode) begin
          count_ff <= 8'h00;
        end else if (match_a && (mode == `TMH_MD_INTERVAL)) begin
          count_ff <= 8'h00;
        end else if (tick) begin
          count_ff <= count_ff + 8'h01;
        end
        if (match_a ^ (match_b && pwm_mode)) begin
          out_ff <= ~out_ff;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/tmh_top.v ***
// timer h channels 0 to 2 with the channel 2 mode register and cpu bus register access
// assumes a single-cycle 8-bit cpu bus; channels 0 and 1 take enable and mode from ports
`timescale 1ns/1ps
`default_nettype none
`include "tmh_regs.vh"
module tmh_top (
  input wire clk,
  input wire rst_n,
  input wire [15:0] bus_addr,
  input wire bus_we,
  input wire bus_re,
  input wire [7:0] bus_wdata,
  output reg [7:0] bus_rdata_ff,
  input wire [1:0] ch_enable,
  input wire [5:0] ch_clock_select,
  input wire [3:0] ch_mode,
  input wire [1:0] ch_level,
  output wire [2:0] timer_match_interrupt,
  output wire [1:0] timer_output,
  output wire event_counter_2_input_enable
);
  reg [7:0] mode2_ff;
  reg [`TMH_PRE_W-1:0] pre_ff;
  reg [`TMH_PRE_W-1:0] pre_q_ff;
  wire [2:0] enable;
  wire [8:0] cks;
  wire [5:0] mode;
  wire [2:0] level;
  wire [2:0] tick;
  wire [2:0] out;
  wire [2:0] cmpa_we;
  wire [2:0] cmpb_we;
  wire [23:0] cmpa;
  wire [23:0] cmpb;
  // --------------------------------
  // tick decode
  // --------------------------------
  // strobe is the rising edge of the divider tap, one clk wide; divide by 1 holds it high every clk and code 7 never strobes
  function tick_of;
    input [2:0] sel;
    input [`TMH_PRE_W-1:0] now;
    input [`TMH_PRE_W-1:0] prev;
    reg [3:0] idx;
    begin
      idx = 4'h0;
      case (sel)
        `TMH_CKS_DIV2: idx = 4'h0;
        `TMH_CKS_DIV4: idx = 4'h1;
        `TMH_CKS_DIV16: idx = 4'h3;
        `TMH_CKS_DIV64: idx = 4'h5;
        `TMH_CKS_DIV1024: idx = 4'h9;
        `TMH_CKS_DIV4096: idx = 4'hb;
        default: idx = 4'h0;
      endcase
      if (sel == `TMH_CKS_DIV1) begin
        tick_of = 1'b1;
      end else if (sel == 3'h7) begin
        tick_of = 1'b0;
      end else begin
        tick_of = now[idx] & ~prev[idx];
      end
    end
  endfunction
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= {`TMH_PRE_W{1'b0}};
      pre_q_ff <= {`TMH_PRE_W{1'b0}};
    end else begin
      pre_ff <= pre_ff + {{(`TMH_PRE_W-1){1'b0}}, 1'b1};
      pre_q_ff <= pre_ff;
    end
  end
  // --------------------------------
  // channel configuration
  // --------------------------------
  assign enable = {mode2_ff[`TMH_MODE_ENABLE], ch_enable};
  assign cks = {mode2_ff[`TMH_MODE_CKS_HI:`TMH_MODE_CKS_LO], ch_clock_select};
  assign mode = {mode2_ff[`TMH_MODE_MD_HI:`TMH_MODE_MD_LO], ch_mode};
  assign level = {mode2_ff[`TMH_MODE_LEVEL], ch_level};
  assign timer_output = out[1:0];
  assign event_counter_2_input_enable = mode2_ff[`TMH_MODE_OUTEN] & out[2];
  assign cmpa_we[0] = bus_we && (bus_addr == `TMH_ADDR_CH0_CMPA);
  assign cmpa_we[1] = bus_we && (bus_addr == `TMH_ADDR_CH1_CMPA);
  assign cmpa_we[2] = bus_we && (bus_addr == `TMH_ADDR_CH2_CMPA);
  assign cmpb_we[0] = bus_we && (bus_addr == `TMH_ADDR_CH0_CMPB);
  assign cmpb_we[1] = bus_we && (bus_addr == `TMH_ADDR_CH1_CMPB);
  assign cmpb_we[2] = bus_we && (bus_addr == `TMH_ADDR_CH2_CMPB);
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_ch
      assign tick[g] = tick_of(cks[3*g+2:3*g], pre_ff, pre_q_ff);
      tmh_channel u_ch (
        .clk(clk),
        .rst_n(rst_n),
        .enable(enable[g]),
        .tick(tick[g]),
        .mode(mode[2*g+1:2*g]),
        .level(level[g]),
        .cmpa_we(cmpa_we[g]),
        .cmpb_we(cmpb_we[g]),
        .wdata(bus_wdata),
        .cmpa(cmpa[8*g+7:8*g]),
        .cmpb(cmpb[8*g+7:8*g]),
        .count_ff(),
        .out_ff(out[g]),
        .irq_ff(timer_match_interrupt[g])
      );
    end
  endgenerate
  // --------------------------------
  // register bus
  // --------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode2_ff <= `TMH_RST_MODE;
      bus_rdata_ff <= 8'h00;
    end else begin
      if (bus_we && (bus_addr == `TMH_ADDR_CH2_MODE)) begin
        mode2_ff <= bus_wdata;
      end
      if (bus_re) begin
        case (bus_addr)
          `TMH_ADDR_CH0_CMPA: bus_rdata_ff <= cmpa[7:0];
          `TMH_ADDR_CH0_CMPB: bus_rdata_ff <= cmpb[7:0];
          `TMH_ADDR_CH1_CMPA: bus_rdata_ff <= cmpa[15:8];
          `TMH_ADDR_CH1_CMPB: bus_rdata_ff <= cmpb[15:8];
          `TMH_ADDR_CH2_MODE: bus_rdata_ff <= mode2_ff;
          `TMH_ADDR_CH2_CMPA: bus_rdata_ff <= cmpa[23:16];
          `TMH_ADDR_CH2_CMPB: bus_rdata_ff <= cmpb[23:16];
          default: bus_rdata_ff <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** test/tmh_top_properties.sv ***
// port checks for the timer h top
// assumes a bind onto tmh_top
`timescale 1ns/1ps
`default_nettype none
module tmh_top_properties (
  input wire clk,
  input wire rst_n,
  input wire [15:0] bus_addr,
  input wire bus_we,
  input wire bus_re,
  input wire [7:0] bus_wdata,
  input wire [7:0] bus_rdata_ff,
  input wire [1:0] ch_enable,
  input wire [5:0] ch_clock_select,
  input wire [3:0] ch_mode,
  input wire [1:0] ch_level,
  input wire [2:0] timer_match_interrupt,
  input wire [1:0] timer_output,
  input wire event_counter_2_input_enable
);
  // ----
  // channel 2 mode shadow
  // ----
  // channel 2 has no enable port, so its state is tracked from bus writes
  reg oe_ff;
  reg en2_ff;
  wire run0;
  assign run0 = ch_enable[0] && ch_mode[1:0] == 2'h0;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_ff <= 1'b0;
      en2_ff <= 1'b0;
    end else if (bus_we && bus_addr == 16'hff42) begin
      oe_ff <= bus_wdata[0];
      en2_ff <= bus_wdata[7];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_DIS_LEVEL:
  assert property ((!ch_enable[0] && $stable(ch_level[0])) [*2] |-> timer_output[0] == ch_level[0])
    else $error("idle level");
  AST_DIS_NO_IRQ:
  assert property (!ch_enable[0] [*2] |-> !timer_match_interrupt[0]) else $error("irq while stopped");
  AST_TOGGLE_IRQ:
  assert property (run0 && $past(run0) && $changed(timer_output[0]) |-> timer_match_interrupt[0])
    else $error("toggle without irq");
  AST_IRQ_TOGGLE:
  assert property (run0 && $past(run0) && timer_match_interrupt[0] |-> $changed(timer_output[0]))
    else $error("irq without toggle");
  AST_RDBACK:
  assert property (bus_we && bus_addr == 16'hff42 ##2 bus_re && bus_addr == 16'hff42 |=>
    bus_rdata_ff == $past(bus_wdata, 3)) else $error("mode readback");
  AST_UNMAPPED:
  assert property (bus_re && bus_addr == 16'hff43 |=> bus_rdata_ff == 8'h00) else $error("unmapped read");
  AST_RD_HOLD:
  assert property (!bus_re |=> $stable(bus_rdata_ff)) else $error("read data moved");
  AST_EVT_GATE:
  assert property (!oe_ff |-> !event_counter_2_input_enable) else $error("event enable not gated");
  AST_CH2_STOP:
  assert property (!en2_ff [*2] |-> !timer_match_interrupt[2]) else $error("ch2 irq while stopped");
  cover property (run0 && timer_match_interrupt[0]);
  cover property (ch_mode[3:2] == 2'h1 && timer_match_interrupt[1]);
  cover property (event_counter_2_input_enable);
endmodule
`default_nettype wire

// *** test/tb_timer_h_compare_and_mode.sv ***
// self-checking bench for the timer h top
// assumes tmh_top and its checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_timer_h_compare_and_mode;
  logic clk = 0, rst_n = 0, bus_we = 0, bus_re = 0, event_counter_2_input_enable;
  logic [15:0] bus_addr = '0;
  logic [7:0] bus_wdata = '0, bus_rdata_ff;
  logic [1:0] ch_enable = '0, ch_level = 2'h3, timer_output;
  logic [5:0] ch_clock_select = '0;
  logic [3:0] ch_mode = '0;
  logic [2:0] timer_match_interrupt;
  int mismatches = 0, checked = 0, cyc = 0, p;
  tmh_top DUT (.*);
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    bus_we = 1;
    bus_addr = a;
    bus_wdata = d;
    @(negedge clk);
    bus_we = 0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    bus_re = 1;
    bus_addr = a;
    @(negedge clk);
    bus_re = 0;
    chk("rdata", e, bus_rdata_ff);
  endtask
  // cycles between two match pulses; the first pulse after enable may come early
  task automatic per(input int c, output int n);
    repeat (2) begin
      n = 0;
      while (timer_match_interrupt[c] !== 1'b1 && n < 9000) begin
        @(negedge clk);
        n++;
      end
      @(negedge clk);
    end
    n++;
  endtask
  task automatic t_regs;
    logic [15:0] a [8] = '{16'hff18, 16'hff19, 16'hff1a, 16'hff1b, 16'hff42, 16'hff44, 16'hff45, 16'hff43};
    foreach (a[i]) rd(a[i], 8'h00);
    foreach (a[i]) wr(a[i], a[i][7:0] ^ 8'h5a);
    foreach (a[i]) rd(a[i], i == 7 ? 8'h00 : a[i][7:0] ^ 8'h5a);
    $display("done regs");
  endtask
  task automatic t_div;
    int d [7] = '{1, 2, 4, 16, 64, 1024, 4096};
    wr(16'hff18, 8'h03);
    ch_enable[0] = 1;
    per(0, p);
    chk("period", 4, p);
    foreach (d[i]) begin
      ch_enable[0] = 0;
      wr(16'hff18, 8'h00);
      ch_clock_select[2:0] = 3'(i);
      ch_enable[0] = 1;
      per(0, p);
      chk("divider", d[i], p);
    end
    ch_enable[0] = 0;
    $display("done div");
  endtask
  task automatic t_carrier;
    ch_mode[3:2] = 2'h1;
    wr(16'hff1a, 8'hc8);
    wr(16'hff1b, 8'h05);
    ch_enable[1] = 1;
    per(1, p);
    chk("carrier", 6, p);
    wr(16'hff1b, 8'h09);
    rd(16'hff1b, 8'h09);
    per(1, p);
    chk("buffered", 10, p);
    // land the next write on the very edge of the next match with the active value
    repeat (7) @(negedge clk);
    wr(16'hff1b, 8'h03);
    per(1, p);
    chk("collide", 10, p);
    per(1, p);
    chk("collide next", 4, p);
    ch_enable[1] = 0;
    ch_mode[3:2] = 2'h2;
    wr(16'hff1b, 8'h09);
    ch_enable[1] = 1;
    p = 0;
    while (timer_output[1] === ch_level[1] && p < 300) begin
      @(negedge clk);
      p++;
    end
    chk("pwm out", !ch_level[1], timer_output[1]);
    chk("pwm irq", 0, timer_match_interrupt[1]);
    ch_enable[1] = 0;
    $display("done carrier");
  endtask
  task automatic t_ch2;
    logic q;
    wr(16'hff44, 8'h02);
    wr(16'hff42, 8'h03);
    rd(16'hff42, 8'h03);
    chk("event level", 1, event_counter_2_input_enable);
    wr(16'hff42, 8'h00);
    rd(16'hff42, 8'h00);
    chk("event off", 0, event_counter_2_input_enable);
    wr(16'hff42, 8'h81);
    per(2, p);
    chk("ch2 period", 3, p);
    q = event_counter_2_input_enable;
    repeat (3) @(negedge clk);
    chk("event toggle", !q, event_counter_2_input_enable);
    wr(16'hff42, 8'h01);
    $display("done ch2");
  endtask
  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1;
    t_regs();
    t_div();
    t_carrier();
    t_ch2();
    end_sim();
  end
endmodule
bind tmh_top tmh_top_properties u_props (.*);
`default_nettype wire
